//--- dv/reset_clock_irq_pin_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected %0t %s", $time, m); end end
module reset_clock_irq_pin_logic_tb;
  import pin_ctl_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wd_fail = 1'b0, cm_fail = 1'b0, stop = 1'b0, single = 1'b0, off = 1'b0;
  logic edge_wr = 1'b0, edge_val = 1'b0, ack = 1'b0, xclr = 1'b0, nmi_n = 1'b1;
  logic ext_low = 1'b0, slow = 1'b0, irq_low = 1'b0, clk_en = 1'b1;
  logic pin_drv, osc_drv;
  logic pin, pin_oe, irq_n, core_rst, internal, valid, bclk, proc, acc;
  logic irq_edge, irq_req, xmask, xreq;
  logic [7:0] s;
  int mismatches = 0, compares = 0, k, n;

  // Clock at 100 MHz.
  always #5 mclk_i = ~mclk_i;

  reset_clock_irq_pin_logic uut (.mclk_i(mclk_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .rst_pin_i(pin), .rst_pin_o(pin_drv), .rst_pin_oe_o(pin_oe), .watchdog_fail_i(wd_fail),
    .clkmon_fail_i(cm_fail), .core_rst_o(core_rst), .rst_internal_o(internal),
    .rst_class_valid_o(valid), .stop_i(stop), .single_chip_i(single),
    .bus_clk_off_i(off), .bus_clk_o(bclk), .proc_phase_o(proc), .access_phase_o(acc),
    .osc_drive_output_o(osc_drv), .irq_n_i(irq_n), .irq_edge_wr_i(edge_wr),
    .irq_edge_val_i(edge_val), .irq_edge_o(irq_edge), .irq_ack_i(ack),
    .irq_req_o(irq_req), .xmask_clr_i(xclr), .nonmaskable_irq_pin_n_i(nmi_n),
    .xmask_o(xmask), .nonmaskable_irq_pin_req_o(xreq));

  reset_irq_far_side far (.mclk_i(mclk_i), .dev_oe_i(pin_oe), .ext_low_i(ext_low),
    .slow_i(slow), .irq_low_i(irq_low), .rst_pin_o(pin), .irq_n_o(irq_n));

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge mclk_i);
  endtask

  // Reset from the dedicated input, then look at the startup state.
  task automatic reset_values;
    rst_i = 1'b1;
    cyc(16);
    rst_i = 1'b0;
    cyc(2);
    `CHK(irq_edge, IRQ_EDGE_RST, "trigger mode after reset")
    `CHK(xmask, XMASK_RST, "mask after reset")
    `CHK(valid, 1'b0, "cause recorded after reset")
    `CHK({core_rst, pin_oe}, 2'b00, "reset outputs idle")
    `CHK(osc_drv, 1'b0, "oscillator drive idle")
  endtask

  // Divide by four, phases, stop and the output disable.
  task automatic bus_clock;
    // The off request alone must not gate the clock outside single-chip mode.
    off = 1'b1;
    for (k = 0; k < 8; k++) begin
      s[k] = bclk;
      `CHK(acc, bclk, "access phase")
      `CHK(proc, ~bclk, "processing phase")
      cyc(1);
    end
    n = 0;
    for (k = 0; k < 7; k++) n += (s[k] != s[k+1]);
    `CHK($countones(s), 4, "bus clock duty")
    `CHK(n >= 3 && n <= 4, 1'b1, "bus clock period")
    stop = 1'b1;
    cyc(2);
    s[0] = bclk;
    for (k = 0; k < 8; k++) begin
      cyc(1);
      `CHK(bclk, s[0], "bus clock runs in stop")
    end
    stop = 1'b0;
    clk_en = 1'b0;
    cyc(1);
    s[0] = bclk;
    cyc(3);
    `CHK(bclk, s[0], "bus clock runs with enable low")
    `CHK(osc_drv, 1'b1, "oscillator drive with enable low")
    clk_en = 1'b1;
    single = 1'b1;
    cyc(2);
    for (k = 0; k < 8; k++) begin
      cyc(1);
      `CHK(bclk, 1'b0, "bus clock not off")
    end
    off = 1'b0;
    single = 1'b0;
    cyc(4);
  endtask

  // Internal failure: a fast rise is internal, a slow one external.
  task automatic internal_reset(input logic slow_pin);
    slow = slow_pin;
    if (slow_pin) cm_fail = 1'b1; else wd_fail = 1'b1;
    cyc(1);
    {wd_fail, cm_fail} = 2'b00;
    cyc(1);
    `CHK({pin_oe, core_rst}, 2'b11, "pin not driven on failure")
    `CHK(pin_drv, 1'b0, "open-drain value not low")
    for (k = 0; k < 120 && core_rst !== 1'b0; k++) cyc(1);
    `CHK({valid, internal}, {1'b1, ~slow_pin}, "reset cause")
    slow = 1'b0;
    cyc(4);
  endtask

  // Pin held low from outside resets the core without the device driving.
  task automatic external_reset;
    ext_low = 1'b1;
    cyc(6);
    `CHK({core_rst, pin_oe}, 2'b10, "external reset not taken")
    ext_low = 1'b0;
    for (k = 0; k < 20 && core_rst !== 1'b0; k++) cyc(1);
    `CHK(core_rst, 1'b0, "core reset stuck")
    `CHK({valid, internal}, 2'b10, "external cause")
    cyc(4);
  endtask

  // Level mode follows the pin; edge mode latches until acknowledged.
  task automatic irq_modes;
    irq_low = 1'b1;
    cyc(1);
    `CHK(irq_req, 1'b0, "request without synchroniser")
    cyc(6);
    `CHK(irq_req, 1'b1, "level request missing")
    irq_low = 1'b0;
    cyc(7);
    `CHK(irq_req, 1'b0, "level request stays")
    // Clear any edge latched during level mode so the check below can fail.
    edge_wr = 1'b1;
    edge_val = 1'b1;
    ack = 1'b1;
    cyc(1);
    edge_wr = 1'b0;
    ack = 1'b0;
    cyc(1);
    `CHK(irq_edge, 1'b1, "edge mode not set")
    `CHK(irq_req, 1'b0, "stale edge request")
    irq_low = 1'b1;
    cyc(3);
    irq_low = 1'b0;
    cyc(8);
    `CHK(irq_req, 1'b1, "edge not latched")
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(1);
    `CHK(irq_req, 1'b0, "edge not cleared")
  endtask

  // The nonmaskable input is ignored until the mask is cleared.
  task automatic nonmaskable;
    nmi_n = 1'b0;
    cyc(6);
    `CHK(xreq, 1'b0, "masked request passes")
    xclr = 1'b1;
    cyc(1);
    xclr = 1'b0;
    cyc(6);
    `CHK({xmask, xreq}, 2'b01, "request after clear")
    nmi_n = 1'b1;
  endtask

  // Everything above should end in a few hundred cycles.
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    @(negedge mclk_i);
    reset_values;
    bus_clock;
    internal_reset(1'b1);
    internal_reset(1'b0);
    external_reset;
    irq_modes;
    nonmaskable;
    reset_values;
    tally_and_finish;
  end
endmodule
`default_nettype wire

//--- dv/reset_irq_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module reset_irq_far_side (
  input  wire logic mclk_i,
  input  wire logic dev_oe_i,
  input  wire logic ext_low_i,
  input  wire logic slow_i,
  input  wire logic irq_low_i,
  output logic      rst_pin_o,
  output logic      irq_n_o
);
  logic [4:0] stretch_q = 5'h00;

  // A slow pull-up keeps the pin low for a while after the device lets go.
  always @(posedge mclk_i) begin
    if (dev_oe_i) begin
      stretch_q <= slow_i ? 5'h14 : 5'h00;
    end else if (stretch_q != 5'h00) begin
      stretch_q <= stretch_q - 5'h01;
    end
  end

  // external low request
  // Open-drain wire with a pull-up: high unless some party pulls it low.
  assign rst_pin_o = ~(dev_oe_i | ext_low_i | (stretch_q != 5'h00));
  // unsynchronised request
  // The source drives the request line with no tie to the device clock.
  assign irq_n_o = ~irq_low_i;
endmodule
`default_nettype wire

//--- rtl/pin_ctl_pkg.sv
package pin_ctl_pkg;

  // Oscillator cycles per bus-phase period (divide by four).
  localparam int unsigned BUS_DIV = 4;
  // Divider phase at which the bus-phase clock rises.
  localparam logic [1:0] PHASE_HIGH = 2'h2;
  // Reset value of the divider phase.
  localparam logic [1:0] PHASE_RST = 2'h0;
  // Internal reset stretch in bus-phase cycles before the pin is released.
  localparam logic [3:0] DRIVE_BUS_CYC = 4'h4;
  // Pin rise limit for an internal cause, in bus-phase cycles.
  localparam logic [3:0] RISE_LIMIT_BUS_CYC = 4'h2;
  // Rise limit counted in oscillator cycles.
  localparam logic [5:0] RISE_LIMIT_CYC = 6'(RISE_LIMIT_BUS_CYC * BUS_DIV);
  // Drive length counted in oscillator cycles.
  localparam logic [5:0] DRIVE_CYC = 6'(DRIVE_BUS_CYC * BUS_DIV);
  // Interrupt trigger mode after reset: level sensitive.
  localparam logic IRQ_EDGE_RST = 1'b0;
  // Nonmaskable mask bit value after reset: set.
  localparam logic XMASK_RST = 1'b1;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRIVE = 2'b01,
    ST_WATCH = 2'b10,
    ST_HOLD  = 2'b11
  } rst_state_t;

endpackage

//--- rtl/reset_clock_irq_pin_logic.sv
`timescale 1ns/1ps
`default_nettype none
module reset_clock_irq_pin_logic
  import pin_ctl_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic clk_en_i,
  input  wire logic rst_pin_i,
  output logic      rst_pin_o,
  output logic      rst_pin_oe_o,
  input  wire logic watchdog_fail_i,
  input  wire logic clkmon_fail_i,
  output logic      core_rst_o,
  output logic      rst_internal_o,
  output logic      rst_class_valid_o,
  input  wire logic stop_i,
  input  wire logic single_chip_i,
  input  wire logic bus_clk_off_i,
  output logic      bus_clk_o,
  output logic      proc_phase_o,
  output logic      access_phase_o,
  output logic      osc_drive_output_o,
  input  wire logic irq_n_i,
  input  wire logic irq_edge_wr_i,
  input  wire logic irq_edge_val_i,
  output logic      irq_edge_o,
  input  wire logic irq_ack_i,
  output logic      irq_req_o,
  input  wire logic xmask_clr_i,
  input  wire logic nonmaskable_irq_pin_n_i,
  output logic      xmask_o,
  output logic      nonmaskable_irq_pin_req_o
);

  // Three-stage synchronisers; stage 1 feeds only stage 2.
  logic [2:0] rpin_q;
  logic [2:0] irq_q;
  logic [2:0] nonmaskable_irq_pin_q;
  logic       rpin_s_q;
  logic       irq_s_q;
  logic       nonmaskable_irq_pin_s_q;
  logic [1:0] phase_q;
  logic       bus_clk_q;
  rst_state_t state_q;
  rst_state_t state_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic       internal_q;
  logic       class_valid_q;
  logic       edge_mode_q;
  logic       irq_pend_q;
  logic       xmask_q;

  wire fail_w        = watchdog_fail_i | clkmon_fail_i;
  wire pin_lo_w      = (rpin_q[2] == rpin_q[1]) ? ~rpin_q[2] : ~rpin_s_q;
  wire irq_lvl_w     = (irq_q[2] == irq_q[1]) ? irq_q[2] : irq_s_q;
  wire nonmaskable_irq_pin_lvl_w    = (nonmaskable_irq_pin_q[2] == nonmaskable_irq_pin_q[1]) ? nonmaskable_irq_pin_q[2] : nonmaskable_irq_pin_s_q;
  wire irq_fall_w    = irq_s_q & ~irq_lvl_w;
  wire in_reset_w    = (state_q != ST_RUN);
  wire clk_run_w     = clk_en_i & ~stop_i;
  wire bus_off_w     = single_chip_i & bus_clk_off_i;

  // Pin synchronisers run on clock enable only; stop freezes only the divider.
  // async capture
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rpin_q   <= 3'h7;
      irq_q    <= 3'h7;
      nonmaskable_irq_pin_q   <= 3'h7;
      rpin_s_q <= 1'b1;
      irq_s_q  <= 1'b1;
      nonmaskable_irq_pin_s_q <= 1'b1;
    end else if (clk_en_i) begin
      rpin_q   <= {rpin_q[1:0], rst_pin_i};
      irq_q    <= {irq_q[1:0], irq_n_i};
      nonmaskable_irq_pin_q   <= {nonmaskable_irq_pin_q[1:0], nonmaskable_irq_pin_n_i};
      rpin_s_q <= ~pin_lo_w;
      irq_s_q  <= irq_lvl_w;
      nonmaskable_irq_pin_s_q <= nonmaskable_irq_pin_lvl_w;
    end
  end

  // Divider: two oscillator cycles low, two high.
  // divide and halt
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q   <= PHASE_RST;
      bus_clk_q <= 1'b0;
    end else if (clk_run_w) begin
      phase_q   <= phase_q + 2'h1;
      bus_clk_q <= ((phase_q + 2'h1) >= PHASE_HIGH);
    end
  end

  assign proc_phase_o   = ~bus_clk_q;
  assign access_phase_o = bus_clk_q;
  assign bus_clk_o          = bus_clk_q & ~bus_off_w;
  assign osc_drive_output_o = ~clk_en_i;

  // Reset sequencer: drive, release, then time the rise.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_RUN: begin
        if (fail_w) begin
          state_d = ST_DRIVE;
          cnt_d   = 6'h00;
        end else if (pin_lo_w) begin
          state_d = ST_HOLD;
        end
      end
      ST_DRIVE: begin
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == DRIVE_CYC - 6'h01) begin
          state_d = ST_WATCH;
          cnt_d   = 6'h00;
        end
      end
      ST_WATCH: begin
        cnt_d = cnt_q + 6'h01;
        if (!pin_lo_w || cnt_q == RISE_LIMIT_CYC) begin
          state_d = pin_lo_w ? ST_HOLD : ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!pin_lo_w) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // Sequencer state and cause classification.
  // classify cause
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q       <= ST_RUN;
      cnt_q         <= 6'h00;
      internal_q    <= 1'b0;
      class_valid_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (state_q == ST_WATCH && state_d == ST_RUN) begin
        internal_q    <= (cnt_q < RISE_LIMIT_CYC);
        class_valid_q <= 1'b1;
      end else if (state_q == ST_HOLD && state_d == ST_RUN) begin
        internal_q    <= 1'b0;
        class_valid_q <= 1'b1;
      end
    end
  end

  // Open drain: output value is always low, only the enable moves.
  // open drain
  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe_o = (state_q == ST_DRIVE);
  assign core_rst_o        = in_reset_w;
  assign rst_internal_o    = internal_q;
  assign rst_class_valid_o = class_valid_q;

  // Trigger mode, pending edge and nonmaskable mask.
  // The edge latch lets a set win over a same-cycle acknowledge.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_mode_q <= IRQ_EDGE_RST;
      irq_pend_q  <= 1'b0;
      xmask_q     <= XMASK_RST;
    end else if (clk_en_i) begin
      if (in_reset_w) begin
        edge_mode_q <= IRQ_EDGE_RST;
        irq_pend_q  <= 1'b0;
        xmask_q     <= XMASK_RST;
      end else begin
        if (irq_edge_wr_i) begin
          edge_mode_q <= irq_edge_val_i;
        end
        if (irq_fall_w) begin
          irq_pend_q <= 1'b1;
        end else if (irq_ack_i) begin
          irq_pend_q <= 1'b0;
        end
        if (xmask_clr_i) begin
          xmask_q <= 1'b0;
        end
      end
    end
  end

  assign irq_edge_o = edge_mode_q;
  assign irq_req_o  = ~in_reset_w & (edge_mode_q ? irq_pend_q : ~irq_s_q);
  assign xmask_o    = xmask_q;
  assign nonmaskable_irq_pin_req_o = ~in_reset_w & ~xmask_q & ~nonmaskable_irq_pin_s_q;

  property p_class_int;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && state_q == ST_WATCH && state_d == ST_RUN && cnt_q < RISE_LIMIT_CYC)
      |=> rst_internal_o && rst_class_valid_o;
  endproperty
  a_class_int: assert property (p_class_int) else $error("fast rise not internal");

  property p_fail_drive;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && state_q == ST_RUN && fail_w) |=> rst_pin_oe_o && !rst_pin_o;
  endproperty
  a_fail_drive: assert property (p_fail_drive) else $error("pin not driven on failure");

  // bus clock high two cycles then low the next cycle
  sequence s_hi2;
    bus_clk_q [*2];
  endsequence
  property p_div4;
    @(posedge mclk_i) disable iff (rst_i || !clk_run_w)
      $rose(bus_clk_q) |-> s_hi2 ##1 !bus_clk_q;
  endproperty
  a_div4: assert property (p_div4) else $error("bus clock not divide by four");

  property p_stop;
    @(posedge mclk_i) disable iff (rst_i)
      (stop_i && clk_en_i) |=> $stable(bus_clk_q);
  endproperty
  a_stop: assert property (p_stop) else $error("bus clock moved in stop");

  property p_off;
    @(posedge mclk_i) disable iff (rst_i)
      (single_chip_i && bus_clk_off_i) |-> !bus_clk_o;
  endproperty
  a_off: assert property (p_off) else $error("bus clock output not disabled");

  // level mode after any reset sequence
  property p_lvl_rst;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && in_reset_w) |=> !irq_edge_o;
  endproperty
  a_lvl_rst: assert property (p_lvl_rst) else $error("edge mode held in reset");

  // mask set during reset blocks the nonmaskable request
  property p_xmask;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && in_reset_w) |=> xmask_o && !nonmaskable_irq_pin_req_o;
  endproperty
  a_xmask: assert property (p_xmask) else $error("mask not set in reset");

  // a level request only rises once stages two and three agree low
  property p_sync;
    @(posedge mclk_i) disable iff (rst_i)
      ($rose(irq_req_o) && !edge_mode_q && !$past(edge_mode_q) && !$past(in_reset_w))
      |-> !$past(irq_q[2]) && !$past(irq_q[1]);
  endproperty
  a_sync: assert property (p_sync) else $error("request before synchronised");

  // edge mode raises a pending request the cycle after a falling edge
  property p_edge;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && !in_reset_w && edge_mode_q && irq_fall_w && !irq_edge_wr_i)
      |=> irq_req_o || in_reset_w;
  endproperty
  a_edge: assert property (p_edge) else $error("edge not latched");

  // a filtered low pin puts the core into reset
  property p_ext_rst;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && state_q == ST_RUN && pin_lo_w) |=> core_rst_o;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("low pin did not reset core");

  // a slow rise records an external cause
  property p_class_ext;
    @(posedge mclk_i) disable iff (rst_i)
      (clk_en_i && state_q == ST_HOLD && state_d == ST_RUN)
      |=> !rst_internal_o && rst_class_valid_o;
  endproperty
  a_class_ext: assert property (p_class_ext) else $error("slow rise not external");

endmodule
`default_nettype wire
